// ### adcc_top.sv
// converter control, result registers and ahb-lite slave
`timescale 1ns/1ps
module adcc_top
	import adcc_pkg::*;
(
	input wire logic hclk, // cpu clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // always okay
	output logic irq, // level interrupt
	output logic [3:0] input_select, // analog mux channel
	output logic converter_on, // analog front end enable
	output logic sample_hold, // high while sampling
	output logic [9:0] trial_code, // trial value for comparator
	input wire logic comp_above // comparator: input at or above trial
);

	typedef struct packed {
		adcc_bus_t bph;
		logic [11:0] addr;
		logic wr;
		logic ready;
		logic resp;
		logic [7:0] rdata;
		logic eoc;
		logic speed;
		logic on;
		logic slow;
		logic [3:0] ch;
		logic [7:0] rhi;
		logic [1:0] rlo;
		logic lock;
		logic [1:0] ist;
		logic [1:0] imsk;
		logic irq;
		adcc_conv_t cv;
		logic [3:0] tcnt;
		logic [3:0] bitn;
		logic [9:0] trial;
		logic sh;
		logic s1;
		logic s2;
		logic s3;
		logic cmp;
	} adcc_state_t;

	adcc_state_t q;
	adcc_state_t n;
	logic csr_wr;
	logic rhi_rd;
	logic rlo_rd;
	logic abort;
	logic conv_done;
	logic lock_now;
	logic [9:0] fin;

	adcc_div_if dv_if ();

	// register index decode, shared by read and write paths
	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		return a == {2'b00, idx, 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// converter clock divider
	adcc_clkdiv u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.dv(dv_if.div)
	);

	assign dv_if.slow = q.slow;
	assign dv_if.speed = q.speed;
	assign dv_if.run = q.on;

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		n = q;
		csr_wr = 1'b0;
		rhi_rd = 1'b0;
		rlo_rd = 1'b0;
		abort = 1'b0;
		conv_done = 1'b0;
		fin = q.trial;
		fin[0] = q.cmp;

		n.s1 = comp_above;
		n.s2 = q.s1;
		n.s3 = q.s2;
		if (q.s2 == q.s3) begin
			n.cmp = q.s3;
		end

		// one wait state per transfer: write data and read side effects
		// land in the data phase, so a read right after a write sees it
		n.ready = 1'b1;
		n.bph = BUS_IDLE;
		if (q.bph == BUS_WAIT) begin
			if (q.wr) begin
				csr_wr = hit(q.addr, IDX_CSR);
				if (hit(q.addr, IDX_IST)) begin
					n.ist = q.ist & ~hwdata[1:0];
				end
				if (hit(q.addr, IDX_IMSK)) begin
					n.imsk = hwdata[1:0];
				end
			end else begin
				rhi_rd = hit(q.addr, IDX_RHI);
				rlo_rd = hit(q.addr, IDX_RLO);
				// flag visible, upper low bits zero
				if (hit(q.addr, IDX_CSR)) begin
					n.rdata = {q.eoc, q.speed, q.on, q.slow, q.ch};
				end else if (hit(q.addr, IDX_RHI)) begin
					n.rdata = q.rhi;
				end else if (hit(q.addr, IDX_RLO)) begin
					n.rdata = {6'h00, q.rlo};
				end else if (hit(q.addr, IDX_IST)) begin
					n.rdata = {6'h00, q.ist};
				end else if (hit(q.addr, IDX_IMSK)) begin
					n.rdata = {6'h00, q.imsk};
				end else begin
					n.rdata = RST_BYTE;
				end
			end
		end else if (hsel && htrans[1] && hready) begin
			n.bph = BUS_WAIT;
			n.ready = 1'b0;
			n.addr = (|haddr[31:12]) ? ADDR_UNMAPPED : haddr[11:0];
			n.wr = hwrite && (hsize == HSIZE_WORD);
		end

		if (csr_wr) begin
			n.eoc = 1'b0;
			n.speed = hwdata[CSR_SPEED_BIT];
			n.on = hwdata[CSR_ON_BIT];
			n.slow = hwdata[CSR_SLOW_BIT];
			n.ch = hwdata[CSR_CH_MSB:0];
			if (!hwdata[CSR_ON_BIT]) begin
				n.cv = CV_OFF;
				n.lock = 1'b0;
				abort = 1'b1;
			end else if (!q.on || hwdata[CSR_CH_MSB:0] != q.ch) begin
				// abort and restart on new channel
				n.cv = CV_SAMPLE;
				abort = 1'b1;
			end
			if (abort) begin
				n.tcnt = 4'h0;
				n.trial = 10'h000;
				n.sh = 1'b0;
			end
		end

		// high read clears flag, and unfreezes
		if (rhi_rd) begin
			n.eoc = 1'b0;
			n.lock = 1'b0;
		end
		if (rlo_rd) begin
			n.lock = 1'b1;
		end
		// a read in this cycle already took the old pair, so honour it now
		lock_now = (q.lock && !rhi_rd) || rlo_rd;

		// sample then one bit per BIT_TICKS ticks
		if (!abort && q.on && dv_if.tick) begin
			case (q.cv)
				CV_SAMPLE: begin
					n.sh = 1'b1;
					if (q.tcnt == SAMPLE_TICKS - 4'h1) begin
						n.cv = CV_BIT;
						n.tcnt = 4'h0;
						n.sh = 1'b0;
						n.bitn = MSB_INDEX;
						n.trial = MSB_TRIAL;
					end else begin
						n.tcnt = q.tcnt + 4'h1;
					end
				end
				CV_BIT: begin
					if (q.tcnt == BIT_TICKS - 4'h1) begin
						n.tcnt = 4'h0;
						n.trial[q.bitn] = q.cmp;
						if (q.bitn == 4'h0) begin
							conv_done = 1'b1;
							n.cv = CV_SAMPLE;
							n.trial = 10'h000;
						end else begin
							n.trial[q.bitn - 4'h1] = 1'b1;
							n.bitn = q.bitn - 4'h1;
						end
					end else begin
						n.tcnt = q.tcnt + 4'h1;
					end
				end
				default: begin
					n.cv = CV_OFF;
				end
			endcase
		end

		// done sets flag, winning over a clear
		if (conv_done) begin
			n.eoc = 1'b1;
			n.ist[IRQ_EOC_BIT] = 1'b1;
			// high byte, low bits, unless frozen
			if (!lock_now) begin
				n.rhi = fin[9:2];
				n.rlo = fin[1:0];
			end else begin
				n.ist[IRQ_OVR_BIT] = 1'b1;
			end
		end

		if (!n.on) begin
			n.cv = CV_OFF;
			n.sh = 1'b0;
			n.tcnt = 4'h0;
			n.trial = 10'h000;
		end

		n.irq = |(n.ist & n.imsk);
	end

	////////////////////////////////////////////////////////////////////////
	// all registers clear on reset, except ready, which resets high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// outputs straight from the state register
	assign hreadyout = q.ready;
	assign hrdata = {24'h000000, q.rdata};
	assign hresp = q.resp;
	assign irq = q.irq;
	// channel drives mux as binary index
	assign input_select = q.ch;
	assign converter_on = q.on;
	assign sample_hold = q.sh;
	assign trial_code = q.trial;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_eoc_set;
		conv_done |=> q.eoc && q.ist[IRQ_EOC_BIT];
	endproperty
	a_eoc_set: assert property (p_eoc_set)
		else $error("done flag not set after conversion");

	property p_eoc_clr;
		(rhi_rd && !conv_done) |=> !q.eoc && hreadyout;
	endproperty
	a_eoc_clr: assert property (p_eoc_clr)
		else $error("high read did not clear done flag");

	property p_off_stops;
		(csr_wr && !hwdata[CSR_ON_BIT]) |=> (q.cv == CV_OFF) && !sample_hold && !q.lock;
	endproperty
	a_off_stops: assert property (p_off_stops)
		else $error("converter still running after off");

	property p_chan_sel;
		csr_wr |=> input_select == $past(hwdata[CSR_CH_MSB:0]);
	endproperty
	a_chan_sel: assert property (p_chan_sel)
		else $error("channel select not taken from write");

	property p_result_store;
		(conv_done && !lock_now) |=> {q.rhi, q.rlo} == $past(fin);
	endproperty
	a_result_store: assert property (p_result_store)
		else $error("result not stored after conversion");

	property p_low_zero;
		(q.bph == BUS_WAIT && !q.wr && hit(q.addr, IDX_RLO)) |=> hrdata[31:2] == 30'h0;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("low result upper bits not zero");

	property p_csr_read;
		(q.bph == BUS_WAIT && !q.wr && hit(q.addr, IDX_CSR))
			|=> hrdata[7:0] == $past({q.eoc, q.speed, q.on, q.slow, q.ch}) && hreadyout;
	endproperty
	a_csr_read: assert property (p_csr_read)
		else $error("control read returned wrong value");

	property p_continuous;
		(conv_done && q.on) |=> q.cv == CV_SAMPLE;
	endproperty
	a_continuous: assert property (p_continuous)
		else $error("no new conversion after done");

	property p_chan_abort;
		(csr_wr && q.on && hwdata[CSR_ON_BIT] && hwdata[CSR_CH_MSB:0] != q.ch)
			|=> (q.cv == CV_SAMPLE) && !q.eoc && (q.tcnt == 4'h0);
	endproperty
	a_chan_abort: assert property (p_chan_abort)
		else $error("channel change did not restart");

	property p_freeze;
		(conv_done && lock_now) |=> $stable(q.rhi) && $stable(q.rlo) && q.ist[IRQ_OVR_BIT];
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("frozen result was overwritten");

	property p_bus_wait;
		(hsel && htrans[1] && hready && q.bph == BUS_IDLE) |=> !hreadyout ##1 hreadyout;
	endproperty
	a_bus_wait: assert property (p_bus_wait)
		else $error("slave did not answer after one wait");

endmodule

// ### adcc_pkg.sv
// shared constants and types of the converter control block
package adcc_pkg;

	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_CSR = 8'h45;
	localparam logic [7:0] IDX_RHI = 8'h46;
	localparam logic [7:0] IDX_RLO = 8'h47;
	localparam logic [7:0] IDX_IST = 8'h48;
	localparam logic [7:0] IDX_IMSK = 8'h49;
	localparam logic [11:0] ADDR_UNMAPPED = 12'hfff;

	// control/status field positions
	localparam int unsigned CSR_EOC_BIT = 7;
	localparam int unsigned CSR_SPEED_BIT = 6;
	localparam int unsigned CSR_ON_BIT = 5;
	localparam int unsigned CSR_SLOW_BIT = 4;
	localparam int unsigned CSR_CH_MSB = 3;

	// interrupt status and mask bit positions
	localparam int unsigned IRQ_EOC_BIT = 0;
	localparam int unsigned IRQ_OVR_BIT = 1;

	// values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;

	// conversion timing in converter clock ticks
	localparam logic [3:0] SAMPLE_TICKS = 4'h4;
	localparam logic [3:0] BIT_TICKS = 4'h6;
	localparam logic [3:0] MSB_INDEX = 4'h9;
	localparam logic [9:0] MSB_TRIAL = 10'h200;

	// divider limits: tick every (limit + 1) cpu clocks
	localparam logic [1:0] DIV_LIM_DIRECT = 2'h0;
	localparam logic [1:0] DIV_LIM_HALF = 2'h1;
	localparam logic [1:0] DIV_LIM_QUARTER = 2'h3;
	// the undivided converter clock is only meant for cpu clocks up to this
	localparam int unsigned DIRECT_CLK_MAX_MHZ = 4;

	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {CV_OFF, CV_SAMPLE, CV_BIT} adcc_conv_t;
	typedef enum logic {BUS_IDLE, BUS_WAIT} adcc_bus_t;

endpackage

// ### adcc_div_if.sv
// converter clock select and tick between control logic and divider
`timescale 1ns/1ps
interface adcc_div_if;
	logic slow;
	logic speed;
	logic run;
	logic tick;
	modport ctrl (output slow, output speed, output run, input tick);
	modport div (input slow, input speed, input run, output tick);
endinterface

// ### adcc_clkdiv.sv
// converter clock divider producing a one-cycle tick per converter clock
`timescale 1ns/1ps
module adcc_clkdiv
	import adcc_pkg::*;
(
	input wire logic hclk, // cpu clock
	input wire logic hresetn, // async reset, active low
	adcc_div_if.div dv // select bits in, tick out
);

	typedef struct packed {
		logic [1:0] cnt;
		logic tick;
	} adcc_div_st_t;

	adcc_div_st_t q;
	adcc_div_st_t n;
	logic [1:0] lim;

	////////////////////////////////////////////////////////////////////////
	// clock select table
	always_comb begin
		n = q;
		if (dv.slow && !dv.speed) begin
			lim = DIV_LIM_QUARTER;
		end else if (!dv.slow && dv.speed) begin
			lim = DIV_LIM_DIRECT;
		end else begin
			lim = DIV_LIM_HALF;
		end
		// counter held at zero while off so each start has a known phase
		if (!dv.run) begin
			n.cnt = 2'h0;
			n.tick = 1'b0;
		end else if (q.cnt >= lim) begin
			n.cnt = 2'h0;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + 2'h1;
			n.tick = 1'b0;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign dv.tick = q.tick;

	////////////////////////////////////////////////////////////////////////
	property p_quarter_rate;
		@(posedge hclk) disable iff (!hresetn)
		(dv.run && dv.slow && !dv.speed && q.tick) ##1 (dv.run && dv.slow && !dv.speed)
			|-> !q.tick ##1 !q.tick;
	endproperty
	a_quarter_rate: assert property (p_quarter_rate)
		else $error("quarter rate tick came too early");

endmodule

// ### adcc_ana_model.sv
// behavioural analog front end: input mux levels and comparator
`timescale 1ns/1ps
module adcc_ana_model (
	input wire logic [3:0] input_select, // selected channel
	input wire logic converter_on, // front end enable
	input wire logic [9:0] trial_code, // trial value
	input wire logic [9:0] tweak, // bench-driven shift of the input levels
	output logic comp_above // input at or above trial
);
	logic [9:0] level;
	// over and under range: top channel above, channel zero below
	always_comb begin
		level = {input_select, 6'h15} ^ tweak;
		if (input_select == 4'hf)
			level = 10'h3ff;
		if (input_select == 4'h0)
			level = 10'h000;
	end
	// one decision per trial; a dead front end gives a moving level, not a held one
	assign comp_above = converter_on ? (level >= trial_code) : trial_code[0];
endmodule

// ### test_adc_control_and_result_regs.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_adc_control_and_result_regs;
	import adcc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [9:0] tweak = 10'h0;
	logic hreadyout, hresp, irq, converter_on, sample_hold, comp_above;
	logic [31:0] hrdata;
	logic [3:0] input_select, ch;
	logic [9:0] trial_code, old;
	logic [7:0] rd, cs;
	int error_cnt = 0;
	int cmp_count = 0;
	int n, dv;
	always #4 hclk = ~hclk;
	adcc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq(irq), .input_select(input_select), .converter_on(converter_on),
		.sample_hold(sample_hold), .trial_code(trial_code), .comp_above(comp_above));
	adcc_ana_model u_ana (.input_select(input_select), .converter_on(converter_on),
		.trial_code(trial_code), .tweak(tweak), .comp_above(comp_above));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one single transfer; the slave's hreadyout is the bus hready
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, {2'b00, idx, 2'b00}, d);
	endtask
	task automatic rreg(input logic [7:0] idx);
		xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00);
	endtask
	// bounded wait for the interrupt line, counting cycles
	task automatic wirq();
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge hclk);
			n++;
		end
	endtask
	function automatic logic [9:0] val(input logic [3:0] c);
		if (c == 4'hf)
			return 10'h3ff;
		if (c == 4'h0)
			return 10'h000;
		return {c, 6'h15} ^ tweak;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs well under 10000 cycles
	initial begin
		repeat (50000) @(posedge hclk);
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// every register reads zero after reset
		for (int i = 0; i < 5; i++) begin
			rreg(IDX_CSR + 8'(i));
			chk("reset value", rd, 0);
		end
		chk("irq after reset", irq, 0);
		chk("hresp", hresp, 0);
		$display("test reset done");
		// field access, read-only places, unmapped word
		wreg(IDX_CSR, 8'h9a);
		rreg(IDX_CSR);
		chk("csr done bit", rd, 8'h1a);
		chk("channel pins", input_select, 4'ha);
		chk("on pin", converter_on, 0);
		wreg(IDX_RHI, 8'hff);
		wreg(IDX_RLO, 8'hff);
		rreg(IDX_RHI);
		chk("high read only", rd, 0);
		rreg(IDX_RLO);
		chk("low read only", rd, 0);
		xfer(1'b1, ADDR_UNMAPPED, 8'hff);
		xfer(1'b0, ADDR_UNMAPPED, 8'h00);
		chk("unmapped", rd, 0);
		wreg(IDX_IMSK, 8'h01);
		$display("test access done");
		// every clock select, over and under range
		for (int m = 0; m < 4; m++) begin
			ch = 4'(m * 5);
			cs = {1'b0, m[0], 1'b1, m[1], ch};
			dv = (m == 1) ? 1 : (m == 2) ? 4 : 2;
			wreg(IDX_CSR, 8'h00);
			wreg(IDX_IST, 8'h03);
			wreg(IDX_CSR, cs);
			wirq();
			chk("conversion time", n >= 64 * dv - 3 && n <= 64 * dv + 4, 1);
			rreg(IDX_CSR);
			chk("done set", rd, {1'b1, cs[6:0]});
			rreg(IDX_RLO);
			chk("low result", rd, {6'h0, val(ch) & 10'h3});
			rreg(IDX_RHI);
			chk("high result", rd, val(ch) >> 2);
			rreg(IDX_CSR);
			chk("done cleared by high read", rd, cs);
			wreg(IDX_IST, 8'h01);
			chk("irq cleared", irq, 0);
			wirq();
			chk("next conversion", n > 0 && n <= 64 * dv + 4, 1);
		end
		$display("test modes done");
		// control write and channel change at direct rate
		cs = 8'h65;
		wreg(IDX_CSR, cs);
		// the status bit is still set from the mode loop, so wait for a fresh end
		wreg(IDX_IST, 8'h01);
		wirq();
		rreg(IDX_CSR);
		chk("done set before write", rd, {1'b1, cs[6:0]});
		wreg(IDX_CSR, cs);
		rreg(IDX_CSR);
		chk("done cleared by write", rd, cs);
		wreg(IDX_IST, 8'h01);
		repeat (30) @(posedge hclk);
		wreg(IDX_CSR, 8'h66);
		wirq();
		chk("restart after channel change", n >= 61 && n <= 68, 1);
		// low read freezes both halves until the high read
		rreg(IDX_RLO);
		old = val(4'h6);
		chk("low before freeze", rd, {6'h0, old & 10'h3});
		tweak <= 10'h3c3;
		wreg(IDX_IST, 8'h03);
		wreg(IDX_IMSK, 8'h02);
		wirq();
		rreg(IDX_RHI);
		chk("high held while frozen", rd, old >> 2);
		wreg(IDX_IST, 8'h03);
		wreg(IDX_IMSK, 8'h01);
		wirq();
		rreg(IDX_RLO);
		chk("low after release", rd, {6'h0, val(4'h6) & 10'h3});
		rreg(IDX_RHI);
		chk("high after release", rd, val(4'h6) >> 2);
		// masked status keeps the line low
		wreg(IDX_IMSK, 8'h00);
		chk("masked irq", irq, 0);
		rreg(IDX_IST);
		chk("status still set", rd[0], 1);
		$display("test control done");
		// clearing the on bit stops every conversion
		wreg(IDX_CSR, 8'h06);
		wreg(IDX_IST, 8'h03);
		repeat (300) @(posedge hclk);
		rreg(IDX_IST);
		chk("no conversion while off", rd, 0);
		chk("on pin off", converter_on, 0);
		chk("hold off", sample_hold, 0);
		chk("trial idle", trial_code, 0);
		$display("test off done");
		close_out();
	end
endmodule
